// file: inc/ctr_host_pkg.sv
package ctr_host_pkg;

    // core clock in MHz and device bus timing, in ns as printed
    localparam int CLK_MHZ = 10;
    localparam int T_WR_NS = 60;
    localparam int T_RD_NS = 110;
    localparam int T_CNT_LOW_NS = 20;
    localparam int T_CNT_HIGH_NS = 30;
    localparam int T_REVERSE_NS = 100;
    localparam int SYNC_STAGES = 2;

    // least times round up to whole cycles
    localparam int WR_CYC = (T_WR_NS * CLK_MHZ + 999) / 1000;
    localparam int RD_CYC = (T_RD_NS * CLK_MHZ + 999) / 1000;
    localparam logic [3:0] WR_STROBE_CYC = 4'(WR_CYC);
    // read strobe also covers the two synchroniser stages on the data pins
    localparam logic [3:0] RD_STROBE_CYC = 4'(RD_CYC + SYNC_STAGES);
    localparam logic [3:0] CNT_LOW_CYC = 4'((T_CNT_LOW_NS * CLK_MHZ + 999) / 1000);
    localparam logic [3:0] CNT_HIGH_CYC = 4'((T_CNT_HIGH_NS * CLK_MHZ + 999) / 1000);
    localparam logic [3:0] REVERSE_CYC = 4'((T_REVERSE_NS * CLK_MHZ + 999) / 1000);

    // software register word indices
    localparam logic [2:0] ADDR_CMD = 3'h0;
    localparam logic [2:0] ADDR_PRESET = 3'h1;
    localparam logic [2:0] ADDR_PULSE = 3'h2;
    localparam logic [2:0] ADDR_PINS = 3'h3;
    localparam logic [2:0] ADDR_STATUS = 3'h4;
    localparam logic [2:0] ADDR_COUNT = 3'h5;

    // field positions
    localparam int CMD_BYTE_LSB = 8;
    localparam int PULSE_DOWN_BIT = 16;
    localparam int PINS_CLEAR_BIT = 0;
    localparam int PINS_LOAD_BIT = 1;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_FLAG_A_BIT = 1;
    localparam int STAT_FLAG_B_BIT = 2;
    localparam int STAT_BYTE_LSB = 8;

    // operations started through ADDR_CMD
    localparam logic [2:0] OP_NONE = 3'h0;
    localparam logic [2:0] OP_WR_CTRL = 3'h1;
    localparam logic [2:0] OP_WR_DATA = 3'h2;
    localparam logic [2:0] OP_RD_STATUS = 3'h3;
    localparam logic [2:0] OP_RD_DATA = 3'h4;
    localparam logic [2:0] OP_READ_COUNT = 3'h5;
    localparam logic [2:0] OP_LOAD_COUNT = 3'h6;
    localparam logic [2:0] OP_PULSES = 3'h7;

    // master command words sent to the device
    localparam logic [7:0] MASTER_PTR_RESET = 8'h01;
    localparam logic [7:0] MASTER_LATCH_AND_PTR = 8'h03;
    localparam logic [7:0] MASTER_PRESET_TO_COUNT = 8'h08;

    // last step index of the multi-access sequences
    localparam logic [2:0] STEP_LAST_READ = 3'h3;
    localparam logic [2:0] STEP_LAST_LOAD = 3'h4;

    // reset levels
    localparam logic [23:0] PRESET_RESET = 24'h000000;
    localparam logic [7:0] BYTE_RESET = 8'h00;

    typedef enum logic [3:0] {
        BUS_IDLE = 4'h1,
        BUS_SETUP = 4'h2,
        BUS_STROBE = 4'h4,
        BUS_HOLD = 4'h8
    } bus_state_e;

    typedef enum logic [5:0] {
        HOST_IDLE = 6'h01,
        HOST_BUS_GO = 6'h02,
        HOST_BUS_WAIT = 6'h04,
        HOST_CNT_DIR = 6'h08,
        HOST_CNT_LOW = 6'h10,
        HOST_CNT_HIGH = 6'h20
    } host_state_e;

endpackage

// file: verilog/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    // pins in, synchronised copy out
    input wire logic [WIDTH-1:0] pin_i,
    output logic [WIDTH-1:0] sync_o
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
    } sync_s;

    sync_s q;
    sync_s d;

    // first stage is read only by the second
    always_comb begin
        d.meta = pin_i;
        d.sync = q.meta;
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign sync_o = q.sync;

endmodule
`default_nettype wire

// file: verilog/dev_bus_cycle.sv
`timescale 1ns/1ps
`default_nettype none
module dev_bus_cycle (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    // access request from the sequencer
    input wire logic go_i,
    input wire logic go_rd_i,
    input wire logic go_cd_i,
    input wire logic [7:0] go_byte_i,
    output logic done_o,
    output logic [7:0] rbyte_o,
    // synchronised device data bus
    input wire logic [7:0] data_sync_i,
    // device bus pins
    output logic cs_n_o,
    output logic rd_n_o,
    output logic wr_n_o,
    output logic cd_o,
    output logic [7:0] data_o,
    output logic data_oe_o
);

    typedef struct packed {
        ctr_host_pkg::bus_state_e state;
        logic [3:0] cnt;
        logic rd;
        logic cs_n;
        logic rd_n;
        logic wr_n;
        logic cd;
        logic [7:0] dout;
        logic oe;
        logic [7:0] rbyte;
        logic done;
    } bus_s;

    bus_s q;
    bus_s d;

    // setup, strobe, hold: select and data stand one cycle either side of the strobe
    always_comb begin
        d = q;
        d.done = 1'b0;
        unique case (q.state)
            ctr_host_pkg::BUS_IDLE: begin
                if (go_i) begin
                    d.cs_n = 1'b0;
                    d.cd = go_cd_i;
                    d.rd = go_rd_i;
                    d.dout = go_byte_i;
                    d.oe = !go_rd_i;
                    d.state = ctr_host_pkg::BUS_SETUP;
                end
            end
            ctr_host_pkg::BUS_SETUP: begin
                d.rd_n = !q.rd;
                d.wr_n = q.rd;
                d.cnt = q.rd ? ctr_host_pkg::RD_STROBE_CYC : ctr_host_pkg::WR_STROBE_CYC;
                d.state = ctr_host_pkg::BUS_STROBE;
            end
            ctr_host_pkg::BUS_STROBE: begin
                d.cnt = q.cnt - 4'h1;
                if (q.cnt == 4'h1) begin
                    // sampled late enough for the synchroniser to carry valid data
                    if (q.rd) begin
                        d.rbyte = data_sync_i;
                    end
                    d.rd_n = 1'b1;
                    d.wr_n = 1'b1;
                    d.state = ctr_host_pkg::BUS_HOLD;
                end
            end
            ctr_host_pkg::BUS_HOLD: begin
                d.cs_n = 1'b1;
                d.oe = 1'b0;
                d.done = 1'b1;
                d.state = ctr_host_pkg::BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            q.state <= ctr_host_pkg::BUS_IDLE;
            q.cnt <= 4'h0;
            q.rd <= 1'b0;
            q.cs_n <= 1'b1;
            q.rd_n <= 1'b1;
            q.wr_n <= 1'b1;
            q.cd <= 1'b0;
            q.dout <= ctr_host_pkg::BYTE_RESET;
            q.oe <= 1'b0;
            q.rbyte <= ctr_host_pkg::BYTE_RESET;
            q.done <= 1'b0;
        end else begin
            q <= d;
        end
    end

    // outputs straight from the state flops
    assign done_o = q.done;
    assign rbyte_o = q.rbyte;
    assign cs_n_o = q.cs_n;
    assign rd_n_o = q.rd_n;
    assign wr_n_o = q.wr_n;
    assign cd_o = q.cd;
    assign data_o = q.dout;
    assign data_oe_o = q.oe;

endmodule
`default_nettype wire

// file: verilog/counter_host.sv
// How it works
// - access only with select low; control/data pin picks control or data side
// - read count: write 3 to master command, then three data reads
// - load count: clear pointer, write three preset bytes, then transfer command
// - with B as direction, B changes only while A is high
//
// Chosen here: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module counter_host (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    // software register port
    input wire logic [2:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    // device parallel bus
    output logic dev_cs_n_o,
    output logic dev_rd_n_o,
    output logic dev_wr_n_o,
    output logic dev_cd_o,
    input wire logic [7:0] dev_data_i,
    output logic [7:0] dev_data_o,
    output logic dev_data_oe_o,
    // device count and control pins
    output logic count_a_o,
    output logic count_b_o,
    output logic ext_count_clear_n_o,
    output logic ext_preset_load_n_o,
    // device status pins
    input wire logic dev_flag_a_i,
    input wire logic dev_flag_b_i
);

    typedef struct packed {
        ctr_host_pkg::host_state_e state;
        logic [2:0] op;
        logic [2:0] step;
        logic [7:0] raw;
        logic [23:0] preset;
        logic [23:0] count;
        logic [7:0] last;
        logic [15:0] pulses;
        logic down;
        logic [3:0] wait_cnt;
        logic clr_n;
        logic load_n;
        logic a;
        logic b;
        logic go;
        logic go_rd;
        logic go_cd;
        logic [7:0] go_byte;
        logic [31:0] rdata;
    } host_s;

    host_s q;
    host_s d;

    logic [9:0] pins_sync_w;
    logic bus_done_w;
    logic [7:0] bus_rbyte_w;
    logic idle_w;
    logic [2:0] last_step_w;
    logic step_rd_w;
    logic step_cd_w;
    logic [7:0] step_byte_w;

    // every pin from the device passes two flops first
    pin_sync #(
        .WIDTH(10)
    ) u_pin_sync (
        .core_clk_i(core_clk_i),
        .rst_b_i(rst_b_i),
        .pin_i({dev_flag_b_i, dev_flag_a_i, dev_data_i}),
        .sync_o(pins_sync_w)
    );

    dev_bus_cycle u_bus (
        .core_clk_i(core_clk_i),
        .rst_b_i(rst_b_i),
        .go_i(q.go),
        .go_rd_i(q.go_rd),
        .go_cd_i(q.go_cd),
        .go_byte_i(q.go_byte),
        .done_o(bus_done_w),
        .rbyte_o(bus_rbyte_w),
        .data_sync_i(pins_sync_w[7:0]),
        .cs_n_o(dev_cs_n_o),
        .rd_n_o(dev_rd_n_o),
        .wr_n_o(dev_wr_n_o),
        .cd_o(dev_cd_o),
        .data_o(dev_data_o),
        .data_oe_o(dev_data_oe_o)
    );

    assign idle_w = (q.state == ctr_host_pkg::HOST_IDLE);

    // the access each step of the current operation makes
    always_comb begin
        step_rd_w = 1'b0;
        step_cd_w = 1'b1;
        step_byte_w = q.raw;
        last_step_w = 3'h0;
        unique case (q.op)
            ctr_host_pkg::OP_WR_DATA: begin
                step_cd_w = 1'b0;
            end
            ctr_host_pkg::OP_RD_STATUS: begin
                step_rd_w = 1'b1;
            end
            ctr_host_pkg::OP_RD_DATA: begin
                step_rd_w = 1'b1;
                step_cd_w = 1'b0;
            end
            ctr_host_pkg::OP_READ_COUNT: begin
                last_step_w = ctr_host_pkg::STEP_LAST_READ;
                if (q.step == 3'h0) begin
                    step_byte_w = ctr_host_pkg::MASTER_LATCH_AND_PTR;
                end else begin
                    step_rd_w = 1'b1;
                    step_cd_w = 1'b0;
                end
            end
            ctr_host_pkg::OP_LOAD_COUNT: begin
                last_step_w = ctr_host_pkg::STEP_LAST_LOAD;
                unique case (q.step)
                    3'h0: step_byte_w = ctr_host_pkg::MASTER_PTR_RESET;
                    3'h1: begin
                        step_cd_w = 1'b0;
                        step_byte_w = q.preset[7:0];
                    end
                    3'h2: begin
                        step_cd_w = 1'b0;
                        step_byte_w = q.preset[15:8];
                    end
                    3'h3: begin
                        step_cd_w = 1'b0;
                        step_byte_w = q.preset[23:16];
                    end
                    default: step_byte_w = ctr_host_pkg::MASTER_PRESET_TO_COUNT;
                endcase
            end
            default: begin
                step_rd_w = 1'b0;
            end
        endcase
    end

    // register port, sequencer and count-pin driver
    always_comb begin
        d = q;
        d.go = 1'b0;
        d.rdata = 32'h00000000;
        // settings only change while idle so a running sequence stays coherent
        if (reg_wr_i && idle_w) begin
            unique case (reg_addr_i)
                ctr_host_pkg::ADDR_CMD: begin
                    d.op = reg_wdata_i[2:0];
                    d.raw = reg_wdata_i[ctr_host_pkg::CMD_BYTE_LSB +: 8];
                    d.step = 3'h0;
                    if (reg_wdata_i[2:0] == ctr_host_pkg::OP_PULSES) begin
                        d.state = ctr_host_pkg::HOST_CNT_DIR;
                        d.wait_cnt = ctr_host_pkg::REVERSE_CYC;
                        // B moves with A idle high, a reversal delay before A falls
                        d.b = q.down;
                    end else if (reg_wdata_i[2:0] != ctr_host_pkg::OP_NONE) begin
                        d.state = ctr_host_pkg::HOST_BUS_GO;
                    end
                end
                ctr_host_pkg::ADDR_PRESET: d.preset = reg_wdata_i[23:0];
                ctr_host_pkg::ADDR_PULSE: begin
                    d.pulses = reg_wdata_i[15:0];
                    d.down = reg_wdata_i[ctr_host_pkg::PULSE_DOWN_BIT];
                end
                ctr_host_pkg::ADDR_PINS: begin
                    d.clr_n = reg_wdata_i[ctr_host_pkg::PINS_CLEAR_BIT];
                    d.load_n = reg_wdata_i[ctr_host_pkg::PINS_LOAD_BIT];
                end
                default: d.op = q.op;
            endcase
        end
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                ctr_host_pkg::ADDR_PRESET: d.rdata = {8'h00, q.preset};
                ctr_host_pkg::ADDR_PULSE: d.rdata = {15'h0000, q.down, q.pulses};
                ctr_host_pkg::ADDR_PINS: d.rdata = {30'h00000000, q.load_n, q.clr_n};
                ctr_host_pkg::ADDR_STATUS: begin
                    d.rdata[ctr_host_pkg::STAT_BUSY_BIT] = !idle_w;
                    d.rdata[ctr_host_pkg::STAT_FLAG_A_BIT] = pins_sync_w[8];
                    d.rdata[ctr_host_pkg::STAT_FLAG_B_BIT] = pins_sync_w[9];
                    d.rdata[ctr_host_pkg::STAT_BYTE_LSB +: 8] = q.last;
                end
                ctr_host_pkg::ADDR_COUNT: d.rdata = {8'h00, q.count};
                default: d.rdata = 32'h00000000;
            endcase
        end
        unique case (q.state)
            ctr_host_pkg::HOST_IDLE: begin
                d.a = 1'b1;
            end
            ctr_host_pkg::HOST_BUS_GO: begin
                d.go = 1'b1;
                d.go_rd = step_rd_w;
                d.go_cd = step_cd_w;
                d.go_byte = step_byte_w;
                d.state = ctr_host_pkg::HOST_BUS_WAIT;
            end
            ctr_host_pkg::HOST_BUS_WAIT: begin
                if (bus_done_w) begin
                    if (q.go_rd) begin
                        d.last = bus_rbyte_w;
                    end
                    if (q.op == ctr_host_pkg::OP_READ_COUNT) begin
                        unique case (q.step)
                            3'h1: d.count[7:0] = bus_rbyte_w;
                            3'h2: d.count[15:8] = bus_rbyte_w;
                            3'h3: d.count[23:16] = bus_rbyte_w;
                            default: d.count = q.count;
                        endcase
                    end
                    if (q.step == last_step_w) begin
                        d.state = ctr_host_pkg::HOST_IDLE;
                    end else begin
                        d.step = q.step + 3'h1;
                        d.state = ctr_host_pkg::HOST_BUS_GO;
                    end
                end
            end
            ctr_host_pkg::HOST_CNT_DIR: begin
                // direction set while A is high
                d.b = q.down;
                d.wait_cnt = q.wait_cnt - 4'h1;
                if (q.wait_cnt == 4'h1) begin
                    if (q.pulses == 16'h0000) begin
                        d.state = ctr_host_pkg::HOST_IDLE;
                    end else begin
                        d.a = 1'b0;
                        d.wait_cnt = ctr_host_pkg::CNT_LOW_CYC;
                        d.state = ctr_host_pkg::HOST_CNT_LOW;
                    end
                end
            end
            ctr_host_pkg::HOST_CNT_LOW: begin
                d.wait_cnt = q.wait_cnt - 4'h1;
                if (q.wait_cnt == 4'h1) begin
                    d.a = 1'b1;
                    d.pulses = q.pulses - 16'h0001;
                    d.wait_cnt = ctr_host_pkg::CNT_HIGH_CYC;
                    d.state = ctr_host_pkg::HOST_CNT_HIGH;
                end
            end
            ctr_host_pkg::HOST_CNT_HIGH: begin
                d.wait_cnt = q.wait_cnt - 4'h1;
                if (q.wait_cnt == 4'h1) begin
                    if (q.pulses == 16'h0000) begin
                        d.state = ctr_host_pkg::HOST_IDLE;
                    end else begin
                        d.a = 1'b0;
                        d.wait_cnt = ctr_host_pkg::CNT_LOW_CYC;
                        d.state = ctr_host_pkg::HOST_CNT_LOW;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            q.state <= ctr_host_pkg::HOST_IDLE;
            q.op <= ctr_host_pkg::OP_NONE;
            q.step <= 3'h0;
            q.raw <= ctr_host_pkg::BYTE_RESET;
            q.preset <= ctr_host_pkg::PRESET_RESET;
            q.count <= ctr_host_pkg::PRESET_RESET;
            q.last <= ctr_host_pkg::BYTE_RESET;
            q.pulses <= 16'h0000;
            q.down <= 1'b0;
            q.wait_cnt <= 4'h0;
            q.clr_n <= 1'b1;
            q.load_n <= 1'b1;
            q.a <= 1'b1;
            q.b <= 1'b0;
            q.go <= 1'b0;
            q.go_rd <= 1'b0;
            q.go_cd <= 1'b0;
            q.go_byte <= ctr_host_pkg::BYTE_RESET;
            q.rdata <= 32'h00000000;
        end else begin
            q <= d;
        end
    end

    // outputs straight from the state flops
    assign reg_rdata_o = q.rdata;
    assign count_a_o = q.a;
    assign count_b_o = q.b;
    assign ext_count_clear_n_o = q.clr_n;
    assign ext_preset_load_n_o = q.load_n;

endmodule
`default_nettype wire

// file: dv/counter_host_chk.sv
`timescale 1ns/1ps
`default_nettype none
module counter_host_chk (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    // device bus
    input wire logic dev_cs_n_o,
    input wire logic dev_rd_n_o,
    input wire logic dev_wr_n_o,
    input wire logic dev_cd_o,
    input wire logic [7:0] dev_data_o,
    input wire logic dev_data_oe_o,
    // count pins
    input wire logic count_a_o,
    input wire logic count_b_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);
    // read strobe covers access time plus two sync stages; select lifts a cycle later
    sequence rd_strobe_s;
        !dev_rd_n_o [*4] ##1 (dev_rd_n_o && !dev_cs_n_o) ##1 dev_cs_n_o;
    endsequence
    // hold cycle keeps data driven, then the bus is let go
    sequence wr_end_s;
        (dev_wr_n_o && !dev_cs_n_o && dev_data_oe_o) ##1 (dev_cs_n_o && !dev_data_oe_o);
    endsequence
    sel_rd_a: assert property (!dev_rd_n_o |-> !dev_cs_n_o && !dev_data_oe_o)
        else $error("read strobe without select or with bus driven");
    sel_wr_a: assert property (!dev_wr_n_o |-> !dev_cs_n_o && dev_rd_n_o)
        else $error("write strobe without select");
    cd_hold_a: assert property (!dev_cs_n_o && !$past(dev_cs_n_o) |-> $stable(dev_cd_o))
        else $error("control/data select moved while selected");
    rd_len_a: assert property ($fell(dev_rd_n_o) |-> rd_strobe_s)
        else $error("read strobe length wrong");
    wr_len_a: assert property ($fell(dev_wr_n_o) |=> wr_end_s)
        else $error("write strobe or hold wrong");
    wr_data_a: assert property (!dev_wr_n_o |-> dev_data_oe_o && $stable(dev_data_o))
        else $error("write data not stable");
    b_dir_a: assert property ($changed(count_b_o) |-> count_a_o && $past(count_a_o))
        else $error("direction changed while A low");
    a_pulse_a: assert property ($fell(count_a_o) |=> count_a_o && count_b_o == $past(count_b_o))
        else $error("count pulse shape wrong");
endmodule
bind counter_host counter_host_chk u_chk (.core_clk_i, .rst_b_i, .dev_cs_n_o, .dev_rd_n_o, .dev_wr_n_o,
    .dev_cd_o, .dev_data_o, .dev_data_oe_o, .count_a_o, .count_b_o);
`default_nettype wire

// file: dv/counter_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
module counter_dev_model #(
    parameter int RD_DELAY_NS = 60
) (
    // parallel bus
    input wire logic cs_n_i,
    input wire logic rd_n_i,
    input wire logic wr_n_i,
    input wire logic cd_i,
    input wire logic [7:0] data_i,
    output logic [7:0] data_o,
    // count and control pins
    input wire logic count_a_i,
    input wire logic count_b_i,
    input wire logic clear_n_i,
    input wire logic load_n_i,
    // status pins
    output logic flag_a_o,
    output logic flag_b_o
);
    logic [23:0] cnt, pre, snap;
    logic [1:0] ptr;
    logic brw_tog, car_tog, cmp_tog, sign, rd_dat;
    logic [7:0] q;
    assign flag_a_o = car_tog;
    assign flag_b_o = brw_tog;
    // start after time zero so reset edges on the pins do not count
    initial begin
        #1;
        {cnt, snap, ptr, brw_tog, car_tog, cmp_tog, rd_dat, q, data_o} = '0;
        pre = 24'hFFFFFF;
        sign = 1'b1;
    end
    always @(posedge wr_n_i) if (!cs_n_i) begin
        if (!cd_i) begin
            pre[ptr*8 +: 8] = data_i;
            ptr = ptr + 2'h1;
        end else if (data_i[7:6] == 2'b00) begin
            if (data_i[5]) {cnt, snap, ptr, brw_tog, car_tog, cmp_tog, pre, sign} = {53'h0, 24'hFFFFFF, 1'b1};
            if (data_i[0]) ptr = 2'h0;
            if (data_i[1]) snap = cnt;
            if (data_i[2]) {cnt, brw_tog, car_tog, sign} = {26'h0, 1'b1};
            if (data_i[3]) cnt = pre;
            if (data_i[4]) cmp_tog = 1'b0;
        end
    end
    // answer a little after the falling strobe
    always @(negedge rd_n_i) if (!cs_n_i) begin
        rd_dat = !cd_i;
        q = cd_i ? {3'h0, 1'b1, sign, cmp_tog, car_tog, brw_tog} : snap[ptr*8 +: 8];
        data_o <= #RD_DELAY_NS q;
    end
    // pointer steps; released bus shows the inverse, not the old byte
    always @(posedge rd_n_i) begin
        if (rd_dat) ptr = ptr + 2'h1;
        rd_dat = 1'b0;
        data_o <= ~q;
    end
    // B high counts down on rising A
    always @(posedge count_a_i) begin
        if (count_b_i) begin
            if (cnt == 24'h0) {brw_tog, sign} = {~brw_tog, 1'b0};
            cnt = cnt - 24'h1;
        end else begin
            if (cnt == 24'hFFFFFF) {car_tog, sign} = {~car_tog, 1'b1};
            cnt = cnt + 24'h1;
        end
        if (cnt == pre) cmp_tog = ~cmp_tog;
    end
    always @(negedge clear_n_i) cnt = 24'h0;
    always @(negedge load_n_i) cnt = pre;
endmodule
`default_nettype wire

// file: dv/counter_host_bench.sv
`timescale 1ns/1ps
`default_nettype none
module counter_host_bench;
    logic core_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [2:0] reg_addr_i = 3'h0;
    logic [31:0] reg_wdata_i = 32'h0;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [31:0] reg_rdata_o, v;
    logic cs_n, rd_n, wr_n, cd, oe, c_a, c_b, clr_n, ld_n, fl_a, fl_b;
    logic [7:0] host_d, dev_d, bus;
    int n_errors = 0;
    int cmp_count = 0;
    // host drives the bus while enabled, otherwise the device does
    assign bus = oe ? host_d : dev_d;
    always #50 core_clk_i = ~core_clk_i;
    counter_host dut (.core_clk_i, .rst_b_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
        .dev_cs_n_o(cs_n), .dev_rd_n_o(rd_n), .dev_wr_n_o(wr_n), .dev_cd_o(cd), .dev_data_i(bus),
        .dev_data_o(host_d), .dev_data_oe_o(oe), .count_a_o(c_a), .count_b_o(c_b),
        .ext_count_clear_n_o(clr_n), .ext_preset_load_n_o(ld_n), .dev_flag_a_i(fl_a), .dev_flag_b_i(fl_b));
    counter_dev_model dev (.cs_n_i(cs_n), .rd_n_i(rd_n), .wr_n_i(wr_n), .cd_i(cd), .data_i(bus), .data_o(dev_d),
        .count_a_i(c_a), .count_b_i(c_b), .clear_n_i(clr_n), .load_n_i(ld_n), .flag_a_o(fl_a), .flag_b_o(fl_b));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task wr(input logic [2:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge core_clk_i);
        reg_wr_i <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe
    task rd(input logic [2:0] a);
        @(posedge core_clk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge core_clk_i);
        reg_rd_i <= 1'b0;
        @(negedge core_clk_i);
        v = reg_rdata_o;
    endtask
    // start an operation and poll busy under a bound
    task cmd(input logic [2:0] op, input logic [7:0] b);
        wr(ctr_host_pkg::ADDR_CMD, {16'h0, b, 5'h0, op});
        for (int i = 0; i < 200; i++) begin
            rd(ctr_host_pkg::ADDR_STATUS);
            if (v[0] === 1'b0) return;
        end
        n_errors++;
        conclude();
    endtask
    task count_is(input logic [31:0] e);
        cmd(ctr_host_pkg::OP_READ_COUNT, 8'h00);
        rd(ctr_host_pkg::ADDR_COUNT);
        chk(v, e);
    endtask
    task status_is(input logic [15:0] e);
        cmd(ctr_host_pkg::OP_RD_STATUS, 8'h00);
        rd(ctr_host_pkg::ADDR_STATUS);
        chk({16'h0, v[15:0]}, {16'h0, e});
    endtask
    task pulses(input logic dn, input logic [15:0] n);
        wr(ctr_host_pkg::ADDR_PULSE, {15'h0, dn, n});
        cmd(ctr_host_pkg::OP_PULSES, 8'h00);
    endtask
    task t_load;
        chk({24'h0, cs_n, rd_n, wr_n, oe, c_a, c_b, clr_n, ld_n}, 32'hEB);
        rd(3'h7);
        chk(v, 32'h0);
        wr(ctr_host_pkg::ADDR_PRESET, 32'h005A3C81);
        rd(ctr_host_pkg::ADDR_PRESET);
        chk(v, 32'h005A3C81);
        cmd(ctr_host_pkg::OP_LOAD_COUNT, 8'h00);
        count_is(32'h005A3C81);
        pulses(1'b0, 16'h5);
        pulses(1'b1, 16'h3);
        pulses(1'b1, 16'h0);
        count_is(32'h005A3C83);
        $display("test load and pulses done");
    endtask
    // underflow then overflow through the cleared counter
    task t_flags;
        wr(ctr_host_pkg::ADDR_PINS, 32'h2);
        wr(ctr_host_pkg::ADDR_PINS, 32'h3);
        pulses(1'b1, 16'h1);
        status_is(16'h1104);
        pulses(1'b0, 16'h1);
        status_is(16'h1B06);
        count_is(32'h0);
        $display("test flags done");
    endtask
    task t_raw;
        cmd(ctr_host_pkg::OP_WR_CTRL, 8'h20);
        status_is(16'h1800);
        wr(ctr_host_pkg::ADDR_PINS, 32'h1);
        wr(ctr_host_pkg::ADDR_PINS, 32'h3);
        count_is(32'h00FFFFFF);
        cmd(ctr_host_pkg::OP_WR_CTRL, 8'h04);
        count_is(32'h0);
        cmd(ctr_host_pkg::OP_WR_CTRL, 8'h01);
        cmd(ctr_host_pkg::OP_WR_DATA, 8'h42);
        cmd(ctr_host_pkg::OP_WR_CTRL, 8'h08);
        count_is(32'h00FFFF42);
        cmd(ctr_host_pkg::OP_WR_CTRL, 8'h03);
        cmd(ctr_host_pkg::OP_RD_DATA, 8'h00);
        rd(ctr_host_pkg::ADDR_STATUS);
        chk({24'h0, v[15:8]}, 32'h42);
        $display("test raw access done");
    endtask
    task conclude;
        $display("compares %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // hold reset, then run the scenarios
    initial begin
        repeat (12) @(posedge core_clk_i);
        rst_b_i <= 1'b1;
        @(posedge core_clk_i);
        t_load();
        t_flags();
        t_raw();
        conclude();
    end
endmodule
`default_nettype wire
